// >>> design/sps_pkg.sv
// Package with register map, field positions, reset values and state types of the SPI port.
package sps_pkg;

  // ---------------------------------------------------------------
  // Register byte addresses
  // ---------------------------------------------------------------
  localparam logic [31:0] ADDR_STAT = 32'hffff0a00;
  localparam logic [31:0] ADDR_RX = 32'hffff0a04;
  localparam logic [31:0] ADDR_TX = 32'hffff0a08;
  localparam logic [31:0] ADDR_DIV = 32'hffff0a0c;
  localparam logic [31:0] ADDR_CTRL = 32'hffff0a10;

  // ---------------------------------------------------------------
  // Control field positions
  // ---------------------------------------------------------------
  localparam int CTL_EN = 0;
  localparam int CTL_MST = 1;
  localparam int CTL_CPHA = 2;
  localparam int CTL_CPOL = 3;
  localparam int CTL_LSB = 5;
  localparam int CTL_TXMODE = 6;
  localparam int CTL_UNF_PREV = 7;
  localparam int CTL_OVF_WR = 8;
  localparam int CTL_SS_OE = 9;
  localparam int CTL_SOE = 10;
  localparam int CTL_LOOP = 11;
  localparam int CTL_CONT = 12;
  localparam int CTL_W = 13;
  localparam logic [CTL_W-1:0] CTL_WMASK = 13'h1fef;

  // ---------------------------------------------------------------
  // Pin synchroniser lanes
  // ---------------------------------------------------------------
  localparam int SY_SCLK = 0;
  localparam int SY_MOSI = 1;
  localparam int SY_SS = 2;
  localparam int SY_MISO = 3;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [CTL_W-1:0] CTRL_RST = 13'h0000;
  localparam logic [7:0] DIV_RST = 8'h1b;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [3:0] SYNC_RST = 4'hf;

  // Transfer engine states.
  typedef enum logic [0:0] {SPS_IDLE, SPS_XFER} sps_st_t;

  // Complete state of the port.
  typedef struct packed {
    sps_st_t st;
    logic [CTL_W-1:0] ctrl;
    logic [7:0] div;
    logic [7:0] rx;
    logic [7:0] tx;
    logic [7:0] last;
    logic [7:0] sh;
    logic [7:0] rsh;
    logic [7:0] cnt;
    logic [31:0] prdata;
    logic [2:0] bits;
    logic h;
    logic tx_full;
    logic rx_full;
    logic rx_ovf;
    logic tx_unf;
    logic tx_irq;
    logic start_req;
    logic rd_skip;
    logic sclk;
    logic dout;
    logic ss_n;
    logic [3:0] s1;
    logic [3:0] s2;
    logic [3:0] s3;
  } sps_state_t;

  localparam sps_state_t SPS_RST = '{st: SPS_IDLE, ctrl: CTRL_RST, div: DIV_RST, rx: BYTE_RST,
    tx: BYTE_RST, ss_n: 1'b1, s1: SYNC_RST, s2: SYNC_RST, s3: SYNC_RST, default: '0};

endpackage

// >>> design/sps_spi_port.sv
// SPI master/slave port with APB registers, status flags and clock divider.
// Operation
// RULE1: Master trigger: bit 6 set starts on transmit write, clear on receive read.
// RULE2: Bit 5 set shifts least significant bit first, else most significant first.
// RULE3: Bit 3 set makes the serial clock rest high, else low.
// RULE4: Bit 2 set pulses clock at bit start, else at bit end.
// RULE5: Bit 1 set selects master role, clear selects slave role.
// RULE6: Bit 0 enables the port; cleared means the port is idle.
// RULE7: Status bit 5 flags a byte arriving while unread data is held.
// RULE8: Status bit 3 shows valid unread received data.
// RULE9: Status bit 4 is set while receive full or overflow is set.
// RULE10: Reading the receive register clears full, interrupt and overflow flags.
// RULE11: Status bit 2 flags a transfer lacking data; transmit write clears it.
// RULE12: Status bit 1 sets on not busy or underflow; cleared by write or disable.
// RULE13: Status bit 0 sets on transmit write and holds until sending ends.
// RULE14: Status register is read-only, resets to zero, top two bits reserved.
// RULE15: Divider register is read/write, resets to 0x1b, sets the bit rate.
// RULE16: Receive register is read-only, resets to zero, holds last received byte.
// RULE17: Transmit register is write-only, resets to zero, queues a byte.
// RULE18: Master clock rate is system clock over two times one plus divider.
// RULE19: In slave mode the active-low select frames bytes until released.
// RULE20: Control bit 8 set overwrites on overflow, clear discards the new byte.
// RULE21: Interrupt follows the flag chosen by the transfer mode bit.
//
// Local design decision: the APB register port.
`timescale 1ns/1ps

module sps_spi_port
  import sps_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sclk_i,
  output logic sclk_o,
  output logic sclk_oe,
  input wire logic mosi_i,
  output logic mosi_o,
  output logic mosi_oe,
  input wire logic miso_i,
  output logic miso_o,
  output logic miso_oe,
  input wire logic ss_n_i,
  output logic ss_n_o,
  output logic ss_n_oe,
  output logic irq
);

  sps_state_t q;
  sps_state_t n;

  logic en;
  logic mst;
  logic lsb;
  logic cpha;
  logic cpol;
  logic busy;
  logic rx_irq;
  logic [7:0] stat;

  // ---------------------------------------------------------------
  // Decoded control and status
  // ---------------------------------------------------------------

  // Mode bits and the status byte as software sees it.
  assign en = q.ctrl[CTL_EN]; // RULE6
  assign mst = q.ctrl[CTL_MST]; // RULE5
  assign lsb = q.ctrl[CTL_LSB];
  assign cpha = q.ctrl[CTL_CPHA];
  assign cpol = q.ctrl[CTL_CPOL];
  assign busy = (q.st == SPS_XFER);
  assign rx_irq = q.rx_full | q.rx_ovf; // RULE9
  assign stat = {2'b00, q.rx_ovf, rx_irq, q.rx_full, q.tx_unf, q.tx_irq, q.tx_full | busy}; // RULE14

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------

  // Bus access, transfer engine and flag updates in one pass.
  always_comb begin
    logic acc;
    logic setup;
    logic wr_tx;
    logic rd_rx;
    logic smp;
    logic adv;
    logic sin;
    logic done;
    logic load;
    logic lead;
    logic trail;
    acc = psel & penable;
    setup = psel & ~penable;
    wr_tx = acc & pwrite & (paddr == ADDR_TX);
    rd_rx = acc & ~pwrite & (paddr == ADDR_RX) & ~q.rd_skip;
    smp = 1'b0;
    adv = 1'b0;
    sin = 1'b0;
    done = 1'b0;
    load = 1'b0;
    lead = (q.s2[SY_SCLK] != q.s3[SY_SCLK]) & (q.s2[SY_SCLK] != cpol);
    trail = (q.s2[SY_SCLK] != q.s3[SY_SCLK]) & (q.s2[SY_SCLK] == cpol);
    n = q;

    // Pin synchroniser; the second stage feeds logic, the third only the clock edge detection.
    n.s1 = {miso_i, ss_n_i, mosi_i, sclk_i};
    n.s2 = q.s1;
    n.s3 = q.s2;

    // Read data is captured in the setup phase.
    n.rd_skip = 1'b0;
    if (setup) begin
      case (paddr)
        ADDR_STAT: n.prdata = {24'h000000, stat};
        ADDR_RX: n.prdata = {24'h000000, q.rx}; // RULE16
        ADDR_DIV: n.prdata = {24'h000000, q.div};
        ADDR_CTRL: n.prdata = {19'h00000, q.ctrl};
        default: n.prdata = 32'h00000000; // RULE17
      endcase
    end

    // Receive read clears the receive flags; a new byte below wins.
    if (rd_rx) begin
      n.rx_full = 1'b0; // RULE10
      n.rx_ovf = 1'b0; // RULE10
      if (mst & ~q.ctrl[CTL_TXMODE]) begin
        n.start_req = 1'b1; // RULE1
      end
    end

    // Transfer engine.
    if (~en) begin
      n.st = SPS_IDLE; // RULE6
      n.sclk = cpol;
      n.ss_n = 1'b1;
      n.h = 1'b0;
      n.start_req = 1'b0;
    end else if (mst) begin
      case (q.st)
        SPS_IDLE: begin
          n.sclk = cpol; // RULE3
          n.ss_n = 1'b1;
          if (q.ctrl[CTL_TXMODE] ? q.tx_full : q.start_req) begin // RULE1
            load = 1'b1;
            n.start_req = 1'b0;
            n.st = SPS_XFER;
            n.ss_n = 1'b0;
            n.cnt = q.div;
            n.h = 1'b0;
            n.bits = 3'd0;
            n.sclk = cpol ^ cpha; // RULE4
          end
        end
        SPS_XFER: begin
          if (q.cnt != 8'h00) begin
            n.cnt = q.cnt - 8'h01; // RULE18
          end else begin
            n.cnt = q.div; // RULE18
            n.h = ~q.h;
            n.sclk = cpol ^ cpha ^ ~q.h; // RULE4
            if (!q.h) begin
              smp = 1'b1;
              sin = q.ctrl[CTL_LOOP] ? q.dout : q.s2[SY_MISO];
            end else begin
              adv = 1'b1;
            end
          end
        end
        default: n.st = SPS_IDLE;
      endcase
    end else begin
      if (q.s2[SY_SS]) begin
        n.st = SPS_IDLE; // RULE19
      end else if (q.st == SPS_IDLE) begin
        load = 1'b1; // RULE19
        n.st = SPS_XFER;
        n.bits = 3'd0;
      end else begin
        sin = q.s2[SY_MOSI];
        smp = cpha ? trail : lead; // RULE4
        adv = trail;
      end
    end

    // Receive shifter.
    if (smp) begin
      n.rsh = lsb ? {sin, q.rsh[7:1]} : {q.rsh[6:0], sin}; // RULE2
    end

    // Bit advance and end of byte.
    if (adv) begin
      n.bits = q.bits + 3'd1;
      n.sh = lsb ? {1'b0, q.sh[7:1]} : {q.sh[6:0], 1'b0}; // RULE2
      if (q.bits == 3'd7) begin
        done = 1'b1;
        if (!mst) begin
          load = 1'b1; // RULE19
        end else if (q.ctrl[CTL_CONT] & (q.tx_full | wr_tx)) begin
          load = 1'b1;
        end else begin
          n.st = SPS_IDLE;
          n.ss_n = 1'b1;
          n.sclk = cpol;
        end
      end
    end

    // Deliver a finished byte to the receive register.
    if (done) begin
      n.rd_skip = setup;
      if (q.rx_full & ~rd_rx) begin
        n.rx_ovf = 1'b1; // RULE7
        if (q.ctrl[CTL_OVF_WR]) begin
          n.rx = n.rsh; // RULE20
        end
      end else begin
        n.rx = n.rsh; // RULE16
        n.rx_full = 1'b1; // RULE8
      end
    end

    // Fetch the next byte to send, or flag underflow.
    if (load) begin
      n.bits = 3'd0;
      if (q.tx_full) begin
        n.sh = q.tx;
        n.last = q.tx;
        n.tx_full = 1'b0; // RULE13
      end else if (wr_tx) begin
        n.sh = pwdata[7:0];
        n.last = pwdata[7:0];
      end else begin
        n.tx_unf = 1'b1; // RULE11
        n.sh = q.ctrl[CTL_UNF_PREV] ? q.last : 8'h00;
      end
    end
    n.dout = lsb ? n.sh[0] : n.sh[7]; // RULE2

    // Register writes.
    if (acc & pwrite) begin
      case (paddr)
        ADDR_CTRL: n.ctrl = pwdata[CTL_W-1:0] & CTL_WMASK;
        ADDR_DIV: n.div = pwdata[7:0]; // RULE15
        ADDR_TX: begin
          n.tx = pwdata[7:0]; // RULE17
          n.tx_unf = 1'b0; // RULE11
          n.tx_full = ~(load & ~q.tx_full); // RULE13
        end
        default: n.div = n.div;
      endcase
    end

    // Transmit interrupt flag.
    if (wr_tx) begin
      n.tx_irq = 1'b0; // RULE12
    end else if (~en & ~busy) begin
      n.tx_irq = 1'b0; // RULE12
    end else if (~(q.tx_full | busy) | q.tx_unf) begin
      n.tx_irq = 1'b1; // RULE12
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------

  // Whole state is loaded with SPS_RST by the synchronous reset.
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= SPS_RST; // RULE14
    end else begin
      q <= n;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------

  // Bus answer: no wait states, error on unmapped addresses.
  assign prdata = q.prdata;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~(paddr inside {ADDR_STAT, ADDR_RX, ADDR_TX, ADDR_DIV, ADDR_CTRL});

  // Pins; the master drives clock and data out, the slave only its data out.
  assign sclk_o = q.sclk;
  assign sclk_oe = en & mst; // RULE5
  assign mosi_o = q.dout;
  assign mosi_oe = en & mst;
  assign miso_o = q.dout;
  assign miso_oe = en & ~mst & ~q.s2[SY_SS] & q.ctrl[CTL_SOE];
  assign ss_n_o = q.ss_n;
  assign ss_n_oe = en & mst & q.ctrl[CTL_SS_OE];

  // Interrupt follows the flag picked by the transfer mode.
  assign irq = en & (q.ctrl[CTL_TXMODE] ? q.tx_irq : rx_irq); // RULE21

endmodule

// >>> tb/sps_port_properties.sv
// Checker of pin and register read relations of the SPI port.
`timescale 1ns/1ps
module sps_port_properties
  import sps_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic sclk_o,
  input wire logic sclk_oe,
  input wire logic mosi_oe,
  input wire logic miso_oe,
  input wire logic ss_n_o,
  input wire logic irq
);
  logic [CTL_W-1:0] ctl_q;
  logic [7:0] div_q;
  logic [8:0] hc_q;
  logic [12:0] lo_q;
  // Mirrors control and divider writes and times half bits and select spans.
  always_ff @(posedge clk) begin
    if (rst) begin
      ctl_q <= '0;
      div_q <= DIV_RST;
    end else if (psel && penable && pwrite) begin
      if (paddr == ADDR_CTRL) ctl_q <= pwdata[CTL_W-1:0];
      if (paddr == ADDR_DIV) div_q <= pwdata[7:0];
    end
    hc_q <= ($changed(sclk_o) || $changed(ss_n_o)) ? 9'd1 : hc_q + 9'd1;
    lo_q <= ss_n_o ? 13'd0 : lo_q + 13'd1;
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence rd_at(a);
    psel && penable && !pwrite && paddr == a;
  endsequence
  sequence frame_end;
    $rose(ss_n_o) && sclk_oe;
  endsequence
  AST_STAT_RSV: assert property (rd_at(ADDR_STAT) |-> prdata[31:6] == 26'h0)
    else $error("Status reserved bits set.");
  AST_TX_WO: assert property (rd_at(ADDR_TX) |-> prdata == 32'h0)
    else $error("Transmit register readable.");
  AST_DIV_RW: assert property (rd_at(ADDR_DIV) |-> prdata == {24'h0, div_q})
    else $error("Divider read differs.");
  AST_OFF: assert property (!ctl_q[CTL_EN] |-> !sclk_oe && !mosi_oe && !miso_oe && !irq)
    else $error("Disabled port active.");
  AST_ROLE: assert property (sclk_oe == (ctl_q[CTL_EN] && ctl_q[CTL_MST]))
    else $error("Clock drive role wrong.");
  AST_SLV: assert property (miso_oe |-> !ctl_q[CTL_MST] && ctl_q[CTL_SOE])
    else $error("Slave output in wrong role.");
  AST_IDLE: assert property (ss_n_o && $past(ss_n_o) && $stable(ctl_q) && sclk_oe |-> sclk_o == ctl_q[CTL_CPOL])
    else $error("Clock idle level wrong.");
  AST_PHASE: assert property ($fell(ss_n_o) && sclk_oe |-> sclk_o == (ctl_q[CTL_CPOL] ^ ctl_q[CTL_CPHA]))
    else $error("Clock level at start wrong.");
  AST_HALF: assert property ($changed(sclk_o) && !ss_n_o && !$past(ss_n_o) |-> hc_q == {1'b0, div_q} + 9'd1)
    else $error("Half bit length wrong.");
  AST_BYTE: assert property (frame_end |-> lo_q == ({5'h0, div_q} + 13'd1) << 4)
    else $error("Byte length wrong.");
endmodule
bind sps_spi_port sps_port_properties chk_u (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .sclk_o(sclk_o), .sclk_oe(sclk_oe),
  .mosi_oe(mosi_oe), .miso_oe(miso_oe), .ss_n_o(ss_n_o), .irq(irq));

// >>> tb/sps_slave_model.sv
// Behavioural SPI slave that answers the port in master mode.
`timescale 1ns/1ps
module sps_slave_model (
  input wire logic sclk,
  input wire logic mosi,
  input wire logic ss_n,
  input wire logic cpol,
  input wire logic cpha,
  input wire logic lsb,
  input wire logic [7:0] tx,
  output logic miso,
  output logic [7:0] rx
);
  int k = 0;
  // Presents the next reply bit in the chosen order.
  task automatic put();
    miso = tx[lsb ? k[2:0] : 3'd7 - k[2:0]];
    k++;
  endtask
  initial begin
    miso = 1'b0;
    rx = 8'h00;
  end
  // A falling select opens a frame; a released line shows the inverse level.
  always @(ss_n) begin
    if (!ss_n) begin
      if (!cpha) put();
    end else begin
      k = 0;
      miso = ~miso;
    end
  end
  // Sampling and shifting edges follow the phase setting.
  // The short wait lets select settle first, since with phase set the first clock edge and the falling select share one step.
  always @(sclk) begin
    #1;
    if (!ss_n) begin
      if ((sclk != cpol) ^ cpha) rx = lsb ? {mosi, rx[7:1]} : {rx[6:0], mosi};
      else put();
    end
  end
endmodule

// >>> tb/tb_top.sv
// Bench: register and transfer checks of the SPI port against a slave model.
`timescale 1ns/1ps
module tb_top;
  import sps_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd_v, ctl;
  logic pready, pslverr, err_v, sclk_o, mosi_o, miso_i, ss_n_o, irq;
  logic [2:0] mc = 3'h0;
  logic [7:0] sdat = 8'h0;
  logic [7:0] rx_m;
  int n_errors = 0;
  int tests_run = 0;
  // Makes the 10 MHz clock.
  always #50 clk = ~clk;
  sps_spi_port dut_u (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sclk_i(1'b0), .sclk_o(sclk_o),
    .sclk_oe(), .mosi_i(1'b0), .mosi_o(mosi_o), .mosi_oe(), .miso_i(miso_i), .miso_o(), .miso_oe(),
    .ss_n_i(1'b1), .ss_n_o(ss_n_o), .ss_n_oe(), .irq(irq));
  sps_slave_model slv_u (.sclk(sclk_o), .mosi(mosi_o), .ss_n(ss_n_o), .cpol(mc[1]), .cpha(mc[0]),
    .lsb(mc[2]), .tx(sdat), .miso(miso_i), .rx(rx_m));
  // Counts a comparison and reports a mismatch.
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Runs one APB transfer and keeps its read data and error.
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd_v = prdata;
    err_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Reads a register and compares it.
  task automatic rd_chk(input string nm, input logic [31:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(nm, rd_v, e);
  endtask
  // Waits for the interrupt, then compares the byte the slave got.
  task automatic done(input logic [7:0] d);
    do @(posedge clk); while (irq !== 1'b1);
    check("slave rx", {24'h0, rx_m}, {24'h0, d});
  endtask
  // Sends one byte in transmit-trigger mode.
  task automatic xfer(input logic [7:0] d, input logic [7:0] s);
    sdat = s;
    apb(1'b1, ADDR_TX, {24'h0, d});
    done(d);
  endtask
  // Prints the counts and the verdict and ends the run.
  task automatic summarize();
    $display("Checks %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Cuts a hung run short.
  initial begin
    repeat (30000) @(posedge clk);
    n_errors++;
    summarize();
  end
  // Main sequence.
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd_chk("stat", ADDR_STAT, 32'h0);
    rd_chk("rx", ADDR_RX, 32'h0);
    rd_chk("div", ADDR_DIV, 32'h1b);
    rd_chk("tx", ADDR_TX, 32'h0);
    apb(1'b1, ADDR_STAT, 32'hff);
    rd_chk("stat", ADDR_STAT, 32'h0);
    rd_chk("hole", 32'hffff0a14, 32'h0);
    check("slverr", {31'h0, err_v}, 32'h1);
    apb(1'b1, ADDR_DIV, 32'h3);
    rd_chk("div", ADDR_DIV, 32'h3);
    for (int m = 0; m < 4; m++) begin
      mc = {m[0], m[1], m[0]};
      ctl = {26'h1, mc[2], 1'b0, mc[1:0], 2'b11};
      apb(1'b1, ADDR_CTRL, ctl);
      sdat = 8'h3a ^ 8'(m << 4);
      apb(1'b1, ADDR_TX, 32'hc5 ^ m);
      rd_chk("stat", ADDR_STAT, 32'h01);
      done(8'hc5 ^ 8'(m));
      rd_chk("stat", ADDR_STAT, 32'h1a);
      rd_chk("rx", ADDR_RX, {24'h0, sdat});
      rd_chk("stat", ADDR_STAT, 32'h02);
    end
    xfer(8'h96, 8'h71);
    xfer(8'h69, 8'he2);
    rd_chk("stat", ADDR_STAT, 32'h3a);
    rd_chk("rx", ADDR_RX, 32'h71);
    apb(1'b1, ADDR_CTRL, ctl | 32'h100);
    xfer(8'h96, 8'h71);
    xfer(8'h69, 8'he2);
    rd_chk("rx", ADDR_RX, 32'he2);
    mc = 3'h0;
    apb(1'b1, ADDR_CTRL, 32'h3);
    sdat = 8'h4e;
    apb(1'b0, ADDR_RX, 32'h0);
    done(8'h00);
    rd_chk("stat", ADDR_STAT, 32'h1e);
    apb(1'b1, ADDR_TX, 32'h5a);
    rd_chk("stat", ADDR_STAT, 32'h19);
    rd_chk("rx", ADDR_RX, 32'h4e);
    done(8'h5a);
    apb(1'b1, ADDR_CTRL, 32'h0);
    rd_chk("stat", ADDR_STAT, 32'h18);
    check("irq", {31'h0, irq}, 32'h0);
    summarize();
  end
endmodule
